// *** logic/udma_host_port.sv ***
`timescale 1ns/10ps
// ==========================================================
// host end of the burst port
// Overview of operation
// - in read bursts host pin means ready, device pin means strobe.
// - in write bursts host pin is strobe, device pin is device ready.
// - each rising and falling strobe edge before stop moves one word.
// - whoever drives the data words also drives the strobe; the crc word is always the host's.
// - sender sets the word and waits for settling before its strobe edge.
// - host selects a burst mode no faster than the device supports.
// - both ends compute crc per burst, host sends its crc at end.
// - host keeps both card enables negated during every burst.
// - host holds the address fixed, zero on the three used lines.
// - host writes no command registers until the command completes.
// - every burst word is sixteen bits wide.
// - host makes no memory or i/o access during a burst.
// - burst starts with device request, host acknowledges after seeing it.
// - stop from host answered by request drop, and the reverse.
module udma_host_port
  import udma_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic dstrobe_clk,
  input wire logic udma_enable,
  input wire logic [2:0] udma_mode,
  input wire logic cmd_start,
  input wire logic cmd_read,
  input wire logic [CNT_W-1:0] cmd_words,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [WORD_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic done,
  input wire logic dmarq_i,
  input wire logic dev_wait_n_i,
  input wire logic [WORD_W-1:0] data_i,
  output logic [WORD_W-1:0] data_o,
  output logic data_oe,
  output logic dmack_n_o,
  output logic stop_o,
  output logic hrdy_strobe_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic ide_chip_select_0_n,
  output logic ide_chip_select_1_n
);

  host_state_t state_r;
  logic dir_rd_r;
  logic [CNT_W-1:0] left_r;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] half_r;
  logic strobe_r;
  logic pend_r;
  logic [WORD_W-1:0] dout_r;
  logic [WORD_W-1:0] rd_data_r;
  logic rd_valid_r;
  logic done_r;
  logic [1:0] rq_sync_r;
  logic [1:0] wait_sync_r;
  logic rise_tgl_r;
  logic fall_tgl_r;
  logic [WORD_W-1:0] rise_word_r;
  logic [WORD_W-1:0] fall_word_r;
  logic [2:0] rise_sync_r;
  logic [2:0] fall_sync_r;
  logic rq_s;
  logic dev_rdy_s;
  logic rx_rise;
  logic rx_fall;
  logic rx_take;
  logic tx_edge;
  logic in_burst;
  logic crc_clear;
  logic crc_en;
  logic [WORD_W-1:0] crc_data;
  logic [15:0] crc_val;

  // ========================================================
  // pin synchronisers, core side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_sync_r <= 2'h0;
      wait_sync_r <= 2'h3;
    end else begin
      rq_sync_r <= {rq_sync_r[0], dmarq_i};
      wait_sync_r <= {wait_sync_r[0], dev_wait_n_i};
    end
  end

  assign rq_s = rq_sync_r[1];
  assign dev_rdy_s = !wait_sync_r[1];

  // ========================================================
  // data-in capture on both edges of the device strobe
  always_ff @(posedge dstrobe_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_word_r <= '0;
      rise_tgl_r <= 1'b0;
    end else begin
      rise_word_r <= data_i;
      rise_tgl_r <= !rise_tgl_r;
    end
  end

  always_ff @(negedge dstrobe_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_word_r <= '0;
      fall_tgl_r <= 1'b0;
    end else begin
      fall_word_r <= data_i;
      fall_tgl_r <= !fall_tgl_r;
    end
  end

  // toggle crossings; words stay put for a full strobe cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sync_r <= 3'h0;
      fall_sync_r <= 3'h0;
    end else begin
      rise_sync_r <= {rise_sync_r[1:0], rise_tgl_r};
      fall_sync_r <= {fall_sync_r[1:0], fall_tgl_r};
    end
  end

  assign rx_rise = rise_sync_r[2] ^ rise_sync_r[1];
  assign rx_fall = fall_sync_r[2] ^ fall_sync_r[1];

  // words count only in a live read burst; the closing edge is ignored
  assign rx_take = dir_rd_r && (rx_rise || rx_fall) && !stop_o &&
                   (state_r == S_XFER || state_r == S_PAUSE);

  // ========================================================
  // data-out strobe timing
  assign tx_edge = !dir_rd_r && state_r == S_XFER && pend_r &&
                   tmr_r == TMR_W'(1) && dev_rdy_s && rq_s;
  assign wr_ready = !dir_rd_r && state_r == S_XFER && !pend_r &&
                    left_r != '0 && dev_rdy_s && rq_s;

  // ========================================================
  // burst sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      dir_rd_r <= 1'b0;
      left_r <= '0;
      tmr_r <= '0;
      half_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_start && udma_enable && cmd_words != '0) begin
            dir_rd_r <= cmd_read;
            left_r <= cmd_words;
            half_r <= half_cycles(udma_mode);
            state_r <= S_WAIT_RQ;
          end
        end
        S_WAIT_RQ: begin
          if (rq_s) begin
            state_r <= S_ACK;
          end
        end
        S_ACK: begin
          if (!rq_s) begin
            state_r <= S_STOP;
          end else if (dir_rd_r || dev_rdy_s) begin
            tmr_r <= half_r;
            state_r <= S_XFER;
          end
        end
        S_XFER: begin
          if (!rq_s) begin
            state_r <= S_STOP;
          end else if (dir_rd_r) begin
            if (rx_take) begin
              left_r <= left_r - CNT_W'(1);
            end
            if (left_r == '0 || (rx_take && left_r == CNT_W'(1))) begin
              tmr_r <= TMR_W'(PAUSE_CYC);
              state_r <= S_PAUSE;
            end
          end else begin
            if (wr_valid && wr_ready) begin
              tmr_r <= half_r;
            end else if (tx_edge) begin
              left_r <= left_r - CNT_W'(1);
              tmr_r <= '0;
            end else if (pend_r && tmr_r > TMR_W'(1) && dev_rdy_s) begin
              tmr_r <= tmr_r - TMR_W'(1);
            end
            if (left_r == '0 && !pend_r) begin
              state_r <= S_STOP;
            end
          end
        end
        S_PAUSE: begin
          if (rx_take && left_r != '0) begin
            left_r <= left_r - CNT_W'(1);
          end
          if (!rq_s || tmr_r == '0) begin
            state_r <= S_STOP;
          end else begin
            tmr_r <= tmr_r - TMR_W'(1);
          end
        end
        S_STOP: begin
          if (!rq_s) begin
            tmr_r <= TMR_W'(CRC_SETUP_CYC);
            state_r <= S_CRC;
          end
        end
        S_CRC: begin
          if (tmr_r == '0) begin
            state_r <= S_END;
          end else begin
            tmr_r <= tmr_r - TMR_W'(1);
          end
        end
        S_END: begin
          if (left_r == '0 && !pend_r) begin
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            tmr_r <= half_r;
            state_r <= S_WAIT_RQ;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // outgoing word and host strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= '0;
      pend_r <= 1'b0;
      strobe_r <= 1'b1;
    end else begin
      if (wr_valid && wr_ready) begin
        dout_r <= wr_data;
        pend_r <= 1'b1;
      end else if (tx_edge) begin
        pend_r <= 1'b0;
      end
      if (tx_edge) begin
        strobe_r <= !strobe_r;
      end else if (state_r == S_STOP && !rq_s) begin
        strobe_r <= 1'b1; // no word moves on this edge
      end
    end
  end

  // ========================================================
  // received words to the user
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rx_take;
      if (rx_take) begin
        rd_data_r <= rx_rise ? rise_word_r : fall_word_r;
      end
    end
  end

  // ========================================================
  // burst crc
  assign crc_clear = state_r == S_WAIT_RQ;
  assign crc_en = rx_take || tx_edge;
  assign crc_data = dir_rd_r ? (rx_rise ? rise_word_r : fall_word_r)
                             : dout_r;

  udma_crc u_crc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(crc_clear),
    .en(crc_en),
    .data(crc_data),
    .crc(crc_val)
  );

  // ========================================================
  // pin drive; acknowledge ends the burst meanings when it drops
  assign in_burst = state_r == S_ACK || state_r == S_XFER ||
                    state_r == S_PAUSE || state_r == S_STOP ||
                    state_r == S_CRC;
  assign dmack_n_o = !in_burst;
  assign stop_o = state_r == S_STOP || state_r == S_CRC;
  // ready low only in the read transfer state, strobe in write bursts
  assign hrdy_strobe_o = !in_burst ? 1'b1 :
                         dir_rd_r ? !(state_r == S_XFER) : strobe_r;
  assign data_o = (state_r == S_CRC) ? crc_val : dout_r;
  // host drives data only in write bursts, crc at any end
  assign data_oe = state_r == S_CRC ||
                   (!dir_rd_r && (state_r == S_XFER || state_r == S_STOP));
  assign addr_o = ADDR_IDLE;
  assign ide_chip_select_0_n = 1'b1;
  assign ide_chip_select_1_n = 1'b1;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign busy = state_r != S_IDLE;
  assign done = done_r;

  // ========================================================
  // checks
  sequence s_ack_rise;
    $fell(dmack_n_o);
  endsequence

  property p_ack_after_rq;
    @(posedge core_clk) disable iff (!rst_n)
      s_ack_rise |-> $past(rq_s);
  endproperty
  a_ack_after_rq: assert property (p_ack_after_rq)
    else $error("acknowledge without request");

  property p_cs_negated;
    @(posedge core_clk) disable iff (!rst_n)
      !dmack_n_o |-> ide_chip_select_0_n && ide_chip_select_1_n;
  endproperty
  a_cs_negated: assert property (p_cs_negated)
    else $error("card enable active in burst");

  property p_addr_fixed;
    @(posedge core_clk) disable iff (!rst_n)
      busy |-> addr_o == ADDR_IDLE && $stable(addr_o);
  endproperty
  a_addr_fixed: assert property (p_addr_fixed)
    else $error("address moved during command");

  property p_data_steady;
    @(posedge core_clk) disable iff (!rst_n)
      tx_edge |-> $stable(dout_r) && data_oe;
  endproperty
  a_data_steady: assert property (p_data_steady)
    else $error("word changed at its strobe edge");

  property p_dev_stop;
    @(posedge core_clk) disable iff (!rst_n)
      state_r == S_XFER && !rq_s |=> stop_o;
  endproperty
  a_dev_stop: assert property (p_dev_stop)
    else $error("no stop after request drop");

  sequence s_ack_drop;
    $rose(dmack_n_o);
  endsequence

  property p_revert;
    @(posedge core_clk) disable iff (!rst_n)
      s_ack_drop |-> !stop_o && hrdy_strobe_o && !data_oe;
  endproperty
  a_revert: assert property (p_revert)
    else $error("pins not reverted");

  property p_read_no_drive;
    @(posedge core_clk) disable iff (!rst_n)
      dir_rd_r && state_r == S_XFER |-> !data_oe;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive)
    else $error("host drives bus in read burst");

  property p_crc_seed;
    @(posedge core_clk) disable iff (!rst_n)
      s_ack_rise |-> crc_val == CRC_SEED;
  endproperty
  a_crc_seed: assert property (p_crc_seed)
    else $error("crc not seeded at burst start");

  property p_strobe_pace;
    @(posedge core_clk) disable iff (!rst_n)
      tx_edge |=> !tx_edge [*2];
  endproperty
  a_strobe_pace: assert property (p_strobe_pace)
    else $error("strobe edges too close");

endmodule

// *** logic/udma_pkg.sv ***
// ==========================================================
// shared constants for the burst host port
package udma_pkg;

  // core clock period in ns
  localparam int unsigned CLK_NS = 10;

  // typical two-word cycle per burst mode, ns, modes 0 to 4
  localparam int unsigned MODE_CNT = 5;
  localparam int unsigned CYC2_NS [MODE_CNT] = '{240, 160, 120, 90, 60};
  localparam logic [2:0] MODE_MAX = 3'h4;

  // recipient pause before asking to stop, ns
  localparam int unsigned PAUSE_NS = 100;
  localparam int unsigned PAUSE_CYC = (PAUSE_NS + CLK_NS - 1) / CLK_NS;

  // crc word setup before the acknowledge is dropped, ns
  localparam int unsigned CRC_SETUP_NS = 70;
  localparam int unsigned CRC_SETUP_CYC =
    (CRC_SETUP_NS + CLK_NS - 1) / CLK_NS;

  // timer width and word widths
  localparam int unsigned TMR_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 3;

  // crc seed and polynomial x^16 + x^12 + x^5 + 1
  localparam logic [15:0] CRC_SEED = 16'h4abb;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // address the host holds during a command
  localparam logic [2:0] ADDR_IDLE = 3'h0;

  // half of the strobe cycle, rounded up to whole core cycles
  function automatic logic [TMR_W-1:0] half_cycles(input logic [2:0] m);
    int unsigned ns;
    ns = (m > MODE_MAX) ? CYC2_NS[MODE_MAX] : CYC2_NS[m];
    return TMR_W'((ns / 2 + CLK_NS - 1) / CLK_NS);
  endfunction

  // host controller states
  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT_RQ,
    S_ACK,
    S_XFER,
    S_PAUSE,
    S_STOP,
    S_CRC,
    S_END
  } host_state_t;

endpackage

// *** logic/udma_crc.sv ***
`timescale 1ns/10ps
// ==========================================================
// burst crc, one 16-bit word per enable, seeded on clear
module udma_crc
  import udma_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic en,
  input wire logic [WORD_W-1:0] data,
  output logic [15:0] crc
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // serial crc unrolled over the word, lsb of the word first
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_nxt = crc_r;
    for (int i = 0; i < WORD_W; i++) begin
      fb = crc_nxt[15] ^ data[i];
      crc_nxt = {crc_nxt[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
  end

  // seed at burst start, update per transferred word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_r <= CRC_SEED;
    end else if (clear) begin
      crc_r <= CRC_SEED;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule

// *** test/udma_dev_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// behavioural device end: request, strobe or ready, crc check
module udma_dev_model
  import udma_pkg::*;
(
  input wire logic link_clk,
  input wire logic core_clk,
  input wire logic dmack_n,
  input wire logic stop,
  input wire logic hstb,
  input wire logic [WORD_W-1:0] bus,
  input wire logic data_oe,
  input wire logic split,
  input wire logic slow,
  output logic dmarq,
  output logic dpin,
  output logic [WORD_W-1:0] data,
  output logic crc_err
);
  logic [WORD_W-1:0] txq[$];
  int wr_left;
  int n;
  logic wmode;
  logic [15:0] crc;
  logic [15:0] last;
  logic dmk_d;

  // one crc step per word, low bit first
  function automatic logic [15:0] step(input logic [15:0] c,
                                       input logic [15:0] d);
    for (int i = 0; i < 16; i++) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // ========================================================
  // burst sequencing, any selected mode is served alike
  // no mode state here, so nothing is lost across host resets
  initial begin
    dmarq = 1'b0;
    dpin = 1'b1;
    data = 16'h5a5a;
    crc_err = 1'b0;
    wr_left = 0;
    wmode = 1'b0;
    crc = CRC_SEED;
    last = 16'h0000;
    dmk_d = 1'b1;
    forever begin
      @(posedge link_clk);
      if (txq.size() > 0 || wr_left > 0) begin
        wmode = (wr_left > 0);
        dmarq <= 1'b1;
        wait (!dmack_n);
        @(posedge link_clk);
        n = 0;
        if (wmode) begin
          dpin <= 1'b0;
          if (slow) begin
            repeat (2) @(posedge link_clk);
            dpin <= 1'b1;
            repeat (3) @(posedge link_clk);
            dpin <= 1'b0;
          end
        end else begin
          while (!stop && txq.size() > 0 && !(split && n == 2)) begin
            if (!hstb) begin
              data <= txq[0];
              crc = step(crc, txq.pop_front());
              n++;
              @(negedge link_clk);
              dpin <= ~dpin;
            end
            @(posedge link_clk);
          end
          if (txq.size() > 0) begin
            repeat (2) @(posedge link_clk);
            dmarq <= 1'b0;
          end
        end
        wait (stop);
        dmarq <= 1'b0;
        @(posedge link_clk);
        dpin <= 1'b1;
        data <= ~data;
        wait (dmack_n);
      end
    end
  end

  // word capture on both host strobe edges of a write burst
  always @(hstb) begin
    if (wmode && !dmack_n && !stop && wr_left > 0) begin
      crc = step(crc, bus);
      wr_left--;
    end
  end

  // fresh seed for every burst
  always @(negedge dmack_n) begin
    crc = CRC_SEED;
  end

  // host crc word compared when the acknowledge is dropped
  always @(posedge core_clk) begin
    dmk_d <= dmack_n;
    if (!dmack_n && data_oe) begin
      last <= bus;
    end
    if (dmack_n && !dmk_d && last !== crc) begin
      crc_err <= 1'b1;
    end
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/10ps
// ==========================================================
// self-checking bench for the burst host port
module tb
  import udma_pkg::*;
;
  logic core_clk, link_clk, rst_n, udma_enable, cmd_start, cmd_read;
  logic [2:0] udma_mode;
  logic [CNT_W-1:0] cmd_words;
  logic [WORD_W-1:0] wr_data, rd_data, data_o, dev_data, data_i;
  logic wr_valid, wr_ready, rd_valid, busy, done, data_oe;
  logic dmarq, dpin, dmack_n, stop, hstb, cs0_n, cs1_n;
  logic split, slow, crc_err, ok;
  logic [ADDR_W-1:0] addr;
  logic [15:0] exp_q[$];
  logic [15:0] wq[$];
  int n_errors = 0;
  int checks_done = 0;

  // shared data wire seen by both ends
  assign data_i = data_oe ? data_o : dev_data;

  udma_host_port u_udma_host_port (
    .core_clk(core_clk), .rst_n(rst_n), .dstrobe_clk(dpin),
    .udma_enable(udma_enable), .udma_mode(udma_mode),
    .cmd_start(cmd_start), .cmd_read(cmd_read), .cmd_words(cmd_words),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .done(done),
    .dmarq_i(dmarq), .dev_wait_n_i(dpin), .data_i(data_i),
    .data_o(data_o), .data_oe(data_oe), .dmack_n_o(dmack_n),
    .stop_o(stop), .hrdy_strobe_o(hstb), .addr_o(addr),
    .ide_chip_select_0_n(cs0_n), .ide_chip_select_1_n(cs1_n));

  udma_dev_model u_udma_dev_model (
    .link_clk(link_clk), .core_clk(core_clk), .dmack_n(dmack_n),
    .stop(stop), .hstb(hstb), .bus(data_i), .data_oe(data_oe),
    .split(split), .slow(slow), .dmarq(dmarq), .dpin(dpin),
    .data(dev_data), .crc_err(crc_err));

  // ========================================================
  // clocks and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  // ========================================================
  // compare helpers and verdict
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    checks_done++;
    if (e !== s) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask

  function automatic logic [15:0] nxt();
    if (exp_q.size() == 0) return 16'hxxxx;
    return exp_q.pop_front();
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ========================================================
  // watchers: take the oldest note when a word shows up
  always @(posedge core_clk) begin
    if (rd_valid) chk("rd_data", nxt(), rd_data);
    if (!dmack_n) begin
      chk("selects", 16'h0003, {14'h0000, cs1_n, cs0_n});
      chk("address", 16'h0000, 16'(addr));
      chk("busy_burst", 16'h0001, {15'h0, busy});
    end
  end
  always @(hstb) begin
    if (!cmd_read && !dmack_n && !stop) chk("data_o", nxt(), data_o);
  end
  // the closing strobe return may meet the host's crc word, so skip stop
  always @(dpin) begin
    if (cmd_read && !dmack_n && !stop)
      chk("owner", 16'h0000, {15'h0, data_oe});
  end
  always @(negedge dmack_n) begin
    chk("request", 16'h0001, {15'h0, dmarq});
  end

  // one command: notes words, feeds writes, waits for done
  task automatic run(input logic rd, input int n, input logic [2:0] m);
    logic [15:0] w;
    int t;
    cmd_read <= rd;
    cmd_words <= 16'(n);
    udma_mode <= m;
    cmd_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      w = 16'($urandom);
      exp_q.push_back(w);
      if (rd) u_udma_dev_model.txq.push_back(w);
      else wq.push_back(w);
    end
    if (!rd) u_udma_dev_model.wr_left = n;
    @(posedge core_clk);
    cmd_start <= 1'b0;
    while (wq.size() > 0) begin
      wr_data <= wq[0];
      wr_valid <= 1'b1;
      @(negedge core_clk);
      ok = wr_ready;
      @(posedge core_clk);
      if (ok) void'(wq.pop_front());
    end
    wr_valid <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 20000) begin
      @(negedge core_clk);
      t++;
    end
    chk("done", 16'h0001, {15'h0, done});
    chk("left", 16'h0000, 16'(exp_q.size()));
    chk("crc", 16'h0000, {15'h0, crc_err});
    @(posedge core_clk);
  endtask

  // ========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    udma_enable = 1'b1;
    udma_mode = 3'h0;
    cmd_start = 1'b0;
    cmd_read = 1'b0;
    cmd_words = 16'h0000;
    wr_data = 16'h0000;
    wr_valid = 1'b0;
    split = 1'b0;
    slow = 1'b0;
    void'($urandom(32'ha6803b07));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int m = 0; m <= int'(MODE_MAX); m++) begin
      run(1'b0, 4 + int'($urandom % 5), 3'(m));
      run(1'b1, 3 + int'($urandom % 6), 3'(m));
      $display("mode %0d write and read done", m);
    end
    split <= 1'b1;
    run(1'b1, 8, 3'h4);
    split <= 1'b0;
    $display("device split read done");
    slow <= 1'b1;
    run(1'b0, 9, 3'h2);
    slow <= 1'b0;
    $display("paused write done");
    // hard reset between commands drops the burst mode
    rst_n <= 1'b0;
    udma_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("reset_ack", 16'h0001, {15'h0, dmack_n});
    rst_n <= 1'b1;
    @(posedge core_clk);
    cmd_start <= 1'b1;
    @(posedge core_clk);
    cmd_start <= 1'b0;
    @(negedge core_clk);
    chk("busy", 16'h0000, {15'h0, busy});
    $display("disabled command done");
    // mode selected again after the reset, a slower one
    @(posedge core_clk);
    udma_enable <= 1'b1;
    run(1'b1, 3, 3'h1);
    $display("read after reset done");
    final_report();
  end
endmodule
